// [ppp_pkg.sv]
// Constants for the host-side parallel port: timing, sizes and states.
// Assumes a single 100 MHz clock with synchronous active-high reset.
// How it works
// - Lines named with _n are active low; asserting drives the active level.
// - Link has 17 lines: eight data, four handshake, two error, two status, one reset.
// - One shared byte path, half duplex; never drive and sample together.
// - Port sends or receives depending on the selected direction.
// - The sender asserts the low strobe to qualify its byte on the data lines.
// - Receiver asserts busy while it cannot accept; sender waits while busy.
// - Host drives direction: high means output, low means input.
// - Host drives low host-online to say it is online.
// - Host asserts low init to soft-reset the peripheral.
// - Default outbound handshake uses busy and ready pulse; modified uses busy only.
package ppp_pkg;
    localparam int          CLK_MHZ       = 100;
    // Data setup before strobe, strobe width, hold after strobe (ns)
    localparam int          SETUP_NS      = 500;
    localparam int          STROBE_NS     = 1000;
    localparam int          HOLD_NS       = 500;
    localparam int          SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int          STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int          HOLD_CYC      = (HOLD_NS * CLK_MHZ + 999) / 1000;
    // Longest wait for a ready pulse before giving up on it (us)
    localparam int          ACK_WAIT_US   = 20;
    localparam int          ACK_WAIT_CYC  = ACK_WAIT_US * CLK_MHZ;
    // Init pulse width (us)
    localparam int          INIT_US       = 10;
    localparam int          INIT_CYC      = INIT_US * CLK_MHZ;
    localparam int          CNT_W         = 12;
    localparam int          DATA_W        = 8;
    localparam int          FIFO_DEPTH    = 4;
    localparam logic [7:0]  DATA_RST      = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_WAIT_ACK, ST_WAIT_FREE, ST_RX_LATCH
    } ppp_state_t;
endpackage : ppp_pkg

// [ppp_fifo.sv]
// Small valid/ready FIFO with parameter width and depth.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ppp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    wire              push;
    wire              pop;

    // Handshake decode
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_ff[rd_ff];

    // Storage and pointers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_ff[wr_ff] <= in_data;
                wr_ff         <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop)
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ppp_fifo
`default_nettype wire

// [ppp_port.sv]
// Host end of a half-duplex parallel printer link with 4-word transmit and receive FIFOs.
// Assumes user-side pins are synchronous to clk; user side is valid/ready.
`timescale 1ns/1ps
`default_nettype none
module ppp_port (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // User control
    input  wire logic       dir_out,          // 1 = host sends, 0 = host receives
    input  wire logic       busy_only_mode,   // Modified outbound handshake
    input  wire logic       bidir_peripheral, // Peripheral pulses ready line
    input  wire logic       host_online,
    input  wire logic       init_req,         // One-cycle request to reset peripheral
    // User transmit stream
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    // User receive stream
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic [7:0]      rx_data,
    // User status
    output logic            stat_paper_fault,
    output logic            stat_general_fault,
    output logic            stat_online,
    output logic            stat_busy,
    output logic            stat_idle,
    // Link data lines
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe,
    // Link handshake lines
    output logic            data_qualify_strobe_n,
    input  wire logic       strobe_in_n,      // Peripheral strobe when receiving
    input  wire logic       ready_pulse_n,
    input  wire logic       busy_in,
    output logic            busy_out,         // Host busy while receiving
    output logic            transfer_direction,
    // Link error and status lines
    input  wire logic       paper_fault,
    input  wire logic       general_fault_n,
    input  wire logic       peripheral_online,
    output logic            host_online_n,
    output logic            peripheral_init_n
);
    // Synchroniser stages: 0 strobe,1 ready,2 busy,3 paper,4 fault_n,5 online
    logic [5:0]           s1_ff;
    logic [5:0]           s2_ff;
    logic                 ack_d_ff;
    logic                 stb_d_ff;
    ppp_pkg::ppp_state_t  state_ff;
    ppp_pkg::ppp_state_t  nxt_state;
    logic [ppp_pkg::CNT_W-1:0] cnt_ff;
    logic [ppp_pkg::CNT_W-1:0] nxt_cnt;
    logic [ppp_pkg::CNT_W-1:0] init_cnt_ff;
    logic [7:0]           byte_ff;
    logic                 stb_n_ff;
    logic                 oe_ff;
    logic                 dir_ff;
    logic                 busy_out_ff;
    logic                 online_n_ff;
    logic                 init_n_ff;
    logic                 rx_push_ff;
    logic [7:0]           rx_byte_ff;
    logic                 rx_busy_ff;
    logic                 pf_ff;
    logic                 gf_ff;
    logic                 on_ff;
    logic                 bz_ff;
    logic                 idle_ff;

    // FIFO wiring
    logic                 txq_valid;
    logic [7:0]           txq_data;
    wire                  txq_pop;
    logic                 rxq_ready;

    // Synchronised inputs and edges
    wire ack_s   = s2_ff[1];
    wire stb_s   = s2_ff[0];
    wire ack_fall = ack_d_ff && !ack_s;
    wire stb_fall = stb_d_ff && !stb_s;
    wire busy_s  = s2_ff[2];
    wire cnt_done = (cnt_ff == '0);
    wire need_ack = !busy_only_mode && bidir_peripheral;
    wire idle     = (state_ff == ppp_pkg::ST_IDLE);
    // Direction may only follow the request when idle and strobe released
    wire dir_chg  = idle && stb_n_ff && (dir_ff != dir_out);
    wire start_tx = idle && dir_ff && !dir_chg && txq_valid && !busy_s;
    wire start_rx = idle && !dir_ff && !dir_chg && stb_fall && init_n_ff;
    // Byte leaves the FIFO as the send starts, so data is set up before the strobe
    assign txq_pop = start_tx;

    // Transmit FIFO stands between the user and the link
    ppp_fifo #(.WIDTH(ppp_pkg::DATA_W), .DEPTH(ppp_pkg::FIFO_DEPTH)) u_txq (
        .clk       (clk),
        .rst       (rst || !init_n_ff),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (txq_valid),
        .out_ready (txq_pop),
        .out_data  (txq_data)
    );

    // Receive FIFO; when full the host holds busy on the link
    ppp_fifo #(.WIDTH(ppp_pkg::DATA_W), .DEPTH(ppp_pkg::FIFO_DEPTH)) u_rxq (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (rx_push_ff),
        .in_ready  (rxq_ready),
        .in_data   (rx_byte_ff),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // Input synchronisers for peripheral-driven lines
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_ff    <= 6'h13;                                  // Inactive levels
            s2_ff    <= 6'h13;
            ack_d_ff <= 1'b1;
            stb_d_ff <= 1'b1;
        end
        else
        begin
            s1_ff    <= {peripheral_online, general_fault_n, paper_fault,
                         busy_in, ready_pulse_n, strobe_in_n};
            s2_ff    <= s1_ff;
            ack_d_ff <= ack_s;
            stb_d_ff <= stb_s;
        end
    end

    // Transfer sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 1'b1;
        unique case (state_ff)
            ppp_pkg::ST_IDLE:
                if (start_tx)
                begin
                    nxt_state = ppp_pkg::ST_SETUP;
                    nxt_cnt   = ppp_pkg::CNT_W'(ppp_pkg::SETUP_CYC);
                end
                else if (start_rx)
                    nxt_state = ppp_pkg::ST_RX_LATCH;
            ppp_pkg::ST_SETUP:
                if (cnt_done)
                begin
                    nxt_state = ppp_pkg::ST_STROBE;
                    nxt_cnt   = ppp_pkg::CNT_W'(ppp_pkg::STROBE_CYC);
                end
            ppp_pkg::ST_STROBE:
                if (cnt_done)
                begin
                    nxt_state = ppp_pkg::ST_HOLD;
                    nxt_cnt   = ppp_pkg::CNT_W'(ppp_pkg::HOLD_CYC);
                end
            ppp_pkg::ST_HOLD:
                if (cnt_done)
                begin
                    nxt_state = need_ack ? ppp_pkg::ST_WAIT_ACK : ppp_pkg::ST_WAIT_FREE;
                    nxt_cnt   = ppp_pkg::CNT_W'(ppp_pkg::ACK_WAIT_CYC);
                end
            ppp_pkg::ST_WAIT_ACK:
                if (ack_fall || cnt_done)
                    nxt_state = ppp_pkg::ST_WAIT_FREE;
            ppp_pkg::ST_WAIT_FREE:
                if (!busy_s)
                    nxt_state = ppp_pkg::ST_IDLE;
            ppp_pkg::ST_RX_LATCH:
                nxt_state = ppp_pkg::ST_IDLE;
        endcase
    end

    // State, counter and link drivers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff    <= ppp_pkg::ST_IDLE;
            cnt_ff      <= '0;
            byte_ff     <= ppp_pkg::DATA_RST;
            stb_n_ff    <= 1'b1;
            oe_ff       <= 1'b0;
            dir_ff      <= 1'b1;
            rx_push_ff  <= 1'b0;
            rx_byte_ff  <= ppp_pkg::DATA_RST;
        end
        else
        begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            if (dir_chg)
                dir_ff <= dir_out;
            if (txq_pop)
                byte_ff <= txq_data;
            // Drive data only when sending, never while receiving
            oe_ff      <= dir_ff && !dir_chg;
            stb_n_ff   <= !(nxt_state == ppp_pkg::ST_STROBE);
            rx_push_ff <= start_rx;
            if (start_rx)
                rx_byte_ff <= data_in;
        end
    end

    // Host online, init pulse and receive busy
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            online_n_ff <= 1'b1;
            init_n_ff   <= 1'b0;                                // Init asserted at reset
            init_cnt_ff <= ppp_pkg::CNT_W'(ppp_pkg::INIT_CYC);
            busy_out_ff <= 1'b1;
            rx_busy_ff  <= 1'b0;
        end
        else
        begin
            online_n_ff <= !host_online;
            if (init_req && idle)
            begin
                init_n_ff   <= 1'b0;
                init_cnt_ff <= ppp_pkg::CNT_W'(ppp_pkg::INIT_CYC);
            end
            else if (init_cnt_ff != '0)
                init_cnt_ff <= init_cnt_ff - 1'b1;
            else
                init_n_ff <= 1'b1;
            // Busy from byte caught until it has entered the FIFO
            rx_busy_ff  <= start_rx || (rx_busy_ff && !rx_push_ff);
            busy_out_ff <= dir_ff || !rxq_ready || rx_busy_ff || start_rx;
        end
    end

    // Status mirrors of the peripheral lines and of the port idle state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pf_ff   <= 1'b0;
            gf_ff   <= 1'b0;
            on_ff   <= 1'b0;
            bz_ff   <= 1'b0;
            idle_ff <= 1'b1;
        end
        else
        begin
            pf_ff   <= s2_ff[3];
            gf_ff   <= !s2_ff[4];
            on_ff   <= s2_ff[5];
            bz_ff   <= busy_s;
            idle_ff <= idle;
        end
    end

    // Pin and status outputs, each straight from a flip-flop
    assign data_out              = byte_ff;
    assign data_oe               = oe_ff;
    assign data_qualify_strobe_n = stb_n_ff;
    assign transfer_direction    = dir_ff;
    assign busy_out              = busy_out_ff;
    assign host_online_n         = online_n_ff;
    assign peripheral_init_n     = init_n_ff;
    assign stat_paper_fault      = pf_ff;
    assign stat_general_fault    = gf_ff;
    assign stat_online           = on_ff;
    assign stat_busy             = bz_ff;
    assign stat_idle             = idle_ff;
endmodule : ppp_port
`default_nettype wire

// [ppp_port_monitor.sv]
// Checker on the pins of the parallel port, bound onto ppp_port.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ppp_port_monitor (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // User side
    input  wire logic       host_online,
    input  wire logic       stat_paper_fault,
    input  wire logic       stat_general_fault,
    // Link side
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       data_qualify_strobe_n,
    input  wire logic       strobe_in_n,
    input  wire logic       busy_in,
    input  wire logic       busy_out,
    input  wire logic       transfer_direction,
    input  wire logic       paper_fault,
    input  wire logic       general_fault_n,
    input  wire logic       host_online_n,
    input  wire logic       peripheral_init_n
);
    localparam int STB_LEN  = ppp_pkg::STROBE_CYC + 1;
    localparam int INIT_MIN = ppp_pkg::INIT_CYC - 1;
    localparam int INIT_MAX = ppp_pkg::INIT_CYC + 2;
    logic [11:0] low_ff;
    logic [11:0] init_ff;
    logic [7:0]  bhi_ff;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Run lengths of strobe low, init low and peripheral busy high
    always_ff @(posedge clk)
    begin
        low_ff  <= (rst || data_qualify_strobe_n) ? 12'h000 : low_ff + 12'h001;
        init_ff <= (rst || peripheral_init_n) ? 12'h000 : init_ff + 12'h001;
        bhi_ff  <= (rst || !busy_in) ? 8'h00 : bhi_ff + {7'h00, bhi_ff != 8'hff};
    end

    a_half_duplex: assert property (
        !transfer_direction && !$past(transfer_direction) |-> !data_oe)
        else $error("Port drives data while receiving");
    a_strobe_owner: assert property (
        !data_qualify_strobe_n |-> transfer_direction && data_oe)
        else $error("Strobe without driving in output direction");
    a_strobe_data: assert property (!data_qualify_strobe_n |-> $stable(data_out))
        else $error("Data moved under strobe");
    a_strobe_width: assert property ($rose(data_qualify_strobe_n) |-> low_ff == STB_LEN)
        else $error("Strobe width wrong");
    a_busy_block: assert property ($fell(data_qualify_strobe_n) |-> bhi_ff < 8'h3c)
        else $error("Strobe while peripheral busy");
    a_rx_busy: assert property (
        $fell(strobe_in_n) && !transfer_direction && peripheral_init_n |-> ##[1:6] busy_out)
        else $error("No busy after inbound strobe");
    a_dir_idle: assert property (
        $changed(transfer_direction) |-> data_qualify_strobe_n && $past(data_qualify_strobe_n))
        else $error("Direction changed during strobe");
    a_online_level: assert property (
        $past(host_online) == $past(host_online, 2) |-> host_online_n == !$past(host_online))
        else $error("Host online line wrong");
    a_init_width: assert property (
        $rose(peripheral_init_n) |-> init_ff >= INIT_MIN && init_ff <= INIT_MAX)
        else $error("Init pulse width wrong");
    a_paper_sync: assert property (
        $past(paper_fault, 3) == $past(paper_fault, 4) |-> stat_paper_fault == $past(paper_fault, 3))
        else $error("Paper fault status wrong");
    a_fault_sync: assert property (
        $past(general_fault_n, 3) == $past(general_fault_n, 4)
        |-> stat_general_fault == !$past(general_fault_n, 3))
        else $error("General fault status wrong");
endmodule : ppp_port_monitor
`default_nettype wire

// [ppp_periph_model.sv]
// Behavioural printer-class peripheral at the far end of the port.
// Assumes the bench resolves the shared data lines into link.
`timescale 1ns/1ps
`default_nettype none
module ppp_periph_model (
    // Clock
    input  wire logic       clk,
    // Lines from the host
    input  wire logic [7:0] link,
    input  wire logic       data_qualify_strobe_n,
    input  wire logic       busy_out,
    input  wire logic       ack_en,          // Pulse the ready line after a byte
    // Lines toward the host
    output logic [7:0]      per_data,
    output logic            strobe_in_n,
    output logic            ready_pulse_n,
    output logic            busy_in
);
    logic [7:0] got_q[$];

    // Take each strobed byte, hold busy, then pulse ready and release busy
    initial
    begin
        per_data = 8'h5a;
        strobe_in_n = 1'h1;
        ready_pulse_n = 1'h1;
        busy_in = 1'h0;
        forever
        begin
            @(posedge clk);
            if (data_qualify_strobe_n === 1'h0)
            begin
                got_q.push_back(link);
                #1 busy_in = 1'h1;
                while (data_qualify_strobe_n !== 1'h1) @(posedge clk);
                repeat (60) @(posedge clk);
                #1 ready_pulse_n = !ack_en;
                repeat (5) @(posedge clk);
                #1 ready_pulse_n = 1'h1;
                busy_in = 1'h0;
            end
        end
    end

    // Send one byte toward the host once it is no longer busy
    task automatic send_byte(input logic [7:0] b);
        int n;
        n = 0;
        while (busy_out !== 1'h0 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        #1 per_data = b;
        repeat (10) @(posedge clk);
        #1 strobe_in_n = 1'h0;
        repeat (10) @(posedge clk);
        #1 strobe_in_n = 1'h1;
        repeat (10) @(posedge clk);
        #1 per_data = ~b;                          // Released lines show no stale byte
    endtask : send_byte
endmodule : ppp_periph_model
`default_nettype wire

// [ppp_port_test.sv]
// Self-checking bench for the parallel port against a peripheral model.
// Assumes package, FIFO, port, monitor and model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ppp_port_test;
    logic       clk, rst, dir_out, busy_only_mode, bidir_peripheral, host_online, init_req;
    logic       tx_valid, tx_ready, rx_valid, rx_ready, ack_en, saw_full;
    logic [7:0] tx_data, rx_data, data_out, per_data, link, data_in;
    logic       stat_paper_fault, stat_general_fault, stat_online, stat_busy, stat_idle;
    logic       data_oe, data_qualify_strobe_n, strobe_in_n, ready_pulse_n, busy_in, busy_out;
    logic       transfer_direction, paper_fault, general_fault_n, peripheral_online;
    logic       host_online_n, peripheral_init_n;
    int         bad_count, num_checks;

    // Shared data lines: the host wins while it drives
    assign link = data_oe ? data_out : per_data;
    assign data_in = link;

    ppp_port i_ppp_port (.*);
    ppp_periph_model i_ppp_periph_model (.*);

    initial clk = 1'h0;
    always #5 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic print_verdict;
        $display("Checks: %0d, mismatches: %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // Offer one byte and hold it until taken; valid stays up for the caller
    task automatic push(input logic [7:0] b);
        int n;
        n = 0;
        tx_data = b;
        tx_valid = 1'h1;
        while (tx_ready !== 1'h1 && n < 5000)
        begin
            saw_full = 1'h1;
            cyc(1);
            n++;
        end
        if (n >= 5000)
            bad_count++;
        cyc(1);
    endtask : push

    // Take one received byte; ready stays up for the caller
    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        rx_ready = 1'h1;
        while (rx_valid !== 1'h1 && n < 100)
        begin
            cyc(1);
            n++;
        end
        if (n >= 100)
            bad_count++;
        check(rx_data, exp, "received byte");
        cyc(1);
    endtask : pop

    task automatic wait_idle;
        int n;
        n = 0;
        while (stat_idle !== 1'h1 && n < 5000)
        begin
            cyc(1);
            n++;
        end
        if (n >= 5000)
            bad_count++;
    endtask : wait_idle

    task automatic t_reset;
        int n;
        n = 0;
        check(data_qualify_strobe_n, 8'h01, "strobe released");
        check(data_oe, 8'h00, "data not driven");
        check(transfer_direction, 8'h01, "direction output");
        check(host_online_n, 8'h01, "host offline");
        check(peripheral_init_n, 8'h00, "init asserted");
        while (peripheral_init_n !== 1'h1 && n < 1200)
        begin
            cyc(1);
            n++;
        end
        check(8'(n > 900 && n < 1100), 8'h01, "init width");
    endtask : t_reset

    // Fill the transmit buffer past full while the peripheral stalls
    task automatic t_send;
        int n;
        int base;
        n = 0;
        base = i_ppp_periph_model.got_q.size();
        saw_full = 1'h0;
        for (int i = 0; i < 6; i++) push(8'ha0 + i[7:0]);
        tx_valid = 1'h0;
        check(8'(saw_full), 8'h01, "buffer refused when full");
        while (i_ppp_periph_model.got_q.size() < base + 6 && n < 5000)
        begin
            cyc(1);
            n++;
        end
        for (int i = 0; i < 6; i++)
            check(i_ppp_periph_model.got_q[base + i], 8'ha0 + i[7:0], "sent byte");
    endtask : t_send

    // Handshake modes: bidir, busy only, ack given, expect ack timeout
    task automatic t_modes;
        logic [3:0] cfg [4] = '{4'b1010, 4'b1001, 4'b1100, 4'b0000};
        int n;
        int base;
        for (int k = 0; k < 4; k++)
        begin
            wait_idle();
            bidir_peripheral = cfg[k][3];
            busy_only_mode = cfg[k][2];
            ack_en = cfg[k][1];
            base = i_ppp_periph_model.got_q.size();
            n = 0;
            push(8'h11);
            push(8'h22);
            tx_valid = 1'h0;
            while (i_ppp_periph_model.got_q.size() < base + 2 && n < 4000)
            begin
                cyc(1);
                n++;
            end
            check(8'(n > 1500), 8'(cfg[k][0]), "ack wait");
            check(8'(i_ppp_periph_model.got_q.size() == base + 2), 8'h01, "delivered");
            cyc(4);
            check(stat_busy, 8'h01, "peripheral busy seen");
            check(stat_idle, 8'h00, "port busy mid byte");
        end
    endtask : t_modes

    // Receive until the buffer is full, then drain it
    task automatic t_receive;
        wait_idle();
        dir_out = 1'h0;
        cyc(5);
        check(transfer_direction, 8'h00, "direction input");
        check(data_oe, 8'h00, "data released");
        for (int i = 0; i < 4; i++) i_ppp_periph_model.send_byte(8'h3c ^ i[7:0]);
        cyc(10);
        check(busy_out, 8'h01, "busy while full");
        for (int i = 0; i < 4; i++) pop(8'h3c ^ i[7:0]);
        rx_ready = 1'h0;
        cyc(10);
        check(busy_out, 8'h00, "busy released");
    endtask : t_receive

    // Fault and online levels in both states, then a peripheral reset
    task automatic t_status;
        for (int s = 0; s < 2; s++)
        begin
            paper_fault = !s[0];
            general_fault_n = s[0];
            peripheral_online = s[0];
            host_online = !s[0];
            cyc(5);
            check(stat_paper_fault, 8'(!s[0]), "paper fault");
            check(stat_general_fault, 8'(!s[0]), "general fault");
            check(stat_online, 8'(s[0]), "online");
            check(host_online_n, 8'(s[0]), "host online");
        end
        init_req = 1'h1;
        cyc(1);
        init_req = 1'h0;
        cyc(5);
        check(peripheral_init_n, 8'h00, "init on request");
    endtask : t_status

    initial
    begin
        {rst, dir_out, bidir_peripheral, ack_en, general_fault_n, peripheral_online} = 6'h3f;
        {busy_only_mode, host_online, init_req, tx_valid, rx_ready, paper_fault} = 6'h00;
        tx_data = 8'h00;
        saw_full = 1'h0;
        bad_count = 0;
        num_checks = 0;
        cyc(10);
        rst = 1'h0;
        t_reset();
        t_send();
        t_modes();
        t_receive();
        t_status();
        print_verdict();
    end

    // Cut a hang short
    initial
    begin
        cyc(30000);
        bad_count++;
        print_verdict();
    end
endmodule : ppp_port_test

bind ppp_port ppp_port_monitor i_ppp_port_monitor (.*);
`default_nettype wire
